// ===== pkg/kwdt_pkg.sv
// Shared constants and types of the keyed watchdog timer
package kwdt_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KICK = 8'h04;

  // ==========================================================================
  // Control register fields and reset values
  localparam int KEY_MSB = 31;
  localparam int KEY_LSB = 24;
  localparam int BODY_MSB = 23;
  localparam int PSEL_MSB = 12;
  localparam int PSEL_LSB = 8;
  localparam int EN_BIT = 0;
  localparam logic [7:0] KEY_ARM = 8'h55;
  localparam logic [7:0] KEY_COMMIT = 8'hAA;
  localparam logic EN_RST = 1'b0;
  localparam logic [4:0] PSEL_RST = 5'h00;
  localparam logic [23:0] BODY_RST = 24'h000000;
  localparam logic [31:0] CNT_RST = 32'h00000000;

  // ==========================================================================
  // Sleep mode codes shared with the power manager
  localparam logic [2:0] SLEEP_RUN = 3'h0;
  localparam logic [2:0] SLEEP_SHUTDOWN = 3'h5;
  localparam logic [2:0] SLEEP_STATIC = 3'h6;

  // ==========================================================================
  // Unlock sequencer states, Gray coded
  typedef enum logic {
    KWDT_LOCKED = 1'b0,
    KWDT_ARMED = 1'b1
  } kwdt_unlock_e;

endpackage

// ===== logic/kwdt_sync.sv
// Three-stage synchroniser with agreement filter for the RC oscillator pin
`timescale 1ns/1ns
module kwdt_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  logic q_nxt;

  // ==========================================================================
  // Filter: a change counts only once stages two and three agree
  always_comb begin
    q_nxt = q_r;
    if (s2_r == s3_r) begin
      q_nxt = s3_r;
    end
  end

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ===== logic/kwdt_top.sv
// Keyed watchdog timer: APB registers, unlock sequencer and RC-driven prescaler
`timescale 1ns/1ns
module kwdt_top (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RC_CLK,
  input wire logic DBG_HALT,
  input wire logic DBG_KEEP_RUN,
  input wire logic [2:0] SLEEP_REQ,
  output logic [2:0] SLEEP_GRANT,
  output logic RC_OSC_EN,
  output logic WDT_RESET_REQ
);

  // ==========================================================================
  // Reset release through two flip-flops
  logic rst_a_r;
  logic rst_b_r;
  logic rst_n;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end

  assign rst_n = rst_b_r;

  // ==========================================================================
  // Helpers
  // Last count value of a period: 2^(sel+1) - 1, wide enough for sel = 31
  function automatic logic [31:0] term_of(input logic [4:0] sel);
    logic [32:0] full;
    full = (33'h000000001 << (6'(sel) + 6'h01)) - 33'h000000001;
    return full[31:0];
  endfunction

  // ==========================================================================
  // RC oscillator edge detection
  logic rc_lvl;
  logic rc_prev_r;
  logic rc_rise;

  kwdt_sync u_rc_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .d(RC_CLK),
    .q(rc_lvl)
  );

  assign rc_rise = rc_lvl & ~rc_prev_r;

  // ==========================================================================
  // APB slave: one wait state, answer registered
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic acc_first;
  logic done;
  logic mapped;
  logic wr_ctrl;
  logic wr_kick;

  // Stored control state and unlock sequencer
  logic en_r;
  logic en_nxt;
  logic [4:0] period_sel_r;
  logic [4:0] period_sel_nxt;
  logic [23:0] armed_body_r;
  logic [23:0] armed_body_nxt;
  kwdt_pkg::kwdt_unlock_e lock_r;
  kwdt_pkg::kwdt_unlock_e lock_nxt;
  logic commit;
  logic [7:0] wkey;

  assign acc_first = PSEL & PENABLE & ~pready_r;
  assign done = PSEL & PENABLE & pready_r;
  assign mapped = (PADDR == kwdt_pkg::ADDR_CTRL) | (PADDR == kwdt_pkg::ADDR_KICK);
  assign wr_ctrl = done & PWRITE & (PADDR == kwdt_pkg::ADDR_CTRL);
  assign wr_kick = done & PWRITE & (PADDR == kwdt_pkg::ADDR_KICK);
  assign wkey = PWDATA[kwdt_pkg::KEY_MSB:kwdt_pkg::KEY_LSB];

  // Read mux is sampled on the first access cycle and held by the flop
  always_comb begin
    pready_nxt = acc_first;
    pslverr_nxt = acc_first & ~mapped;
    prdata_nxt = 32'h00000000;
    if (acc_first && !PWRITE && PADDR == kwdt_pkg::ADDR_CTRL) begin
      prdata_nxt[kwdt_pkg::PSEL_MSB:kwdt_pkg::PSEL_LSB] = period_sel_r;
      prdata_nxt[kwdt_pkg::EN_BIT] = en_r;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ==========================================================================
  // Unlock sequencer: arm on 0x55, commit on 0xAA with the same body
  always_comb begin
    lock_nxt = lock_r;
    armed_body_nxt = armed_body_r;
    en_nxt = en_r;
    period_sel_nxt = period_sel_r;
    commit = 1'b0;
    if (wr_ctrl) begin
      if (wkey == kwdt_pkg::KEY_ARM) begin
        lock_nxt = kwdt_pkg::KWDT_ARMED;
        armed_body_nxt = PWDATA[kwdt_pkg::BODY_MSB:0];
      end else if (wkey == kwdt_pkg::KEY_COMMIT && lock_r == kwdt_pkg::KWDT_ARMED &&
                   PWDATA[kwdt_pkg::BODY_MSB:0] == armed_body_r) begin
        lock_nxt = kwdt_pkg::KWDT_LOCKED;
        commit = 1'b1;
        en_nxt = PWDATA[kwdt_pkg::EN_BIT];
        period_sel_nxt = PWDATA[kwdt_pkg::PSEL_MSB:kwdt_pkg::PSEL_LSB];
      end else begin
        lock_nxt = kwdt_pkg::KWDT_LOCKED;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      lock_r <= kwdt_pkg::KWDT_LOCKED;
      armed_body_r <= kwdt_pkg::BODY_RST;
      en_r <= kwdt_pkg::EN_RST;
      period_sel_r <= kwdt_pkg::PSEL_RST;
    end else begin
      lock_r <= lock_nxt;
      armed_body_r <= armed_body_nxt;
      en_r <= en_nxt;
      period_sel_r <= period_sel_nxt;
    end
  end

  // ==========================================================================
  // Prescaler and time-out
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic run;
  logic kick_acc;
  logic tmo_evt;
  logic rst_req_nxt;
  logic rc_en_nxt;
  logic [2:0] grant_nxt;
  logic rst_req_r;
  logic rc_en_r;
  logic [2:0] grant_r;

  assign run = ~DBG_HALT | DBG_KEEP_RUN;
  assign kick_acc = wr_kick & en_r;
  // A kick in the expiry cycle wins: it arrived before the period ended
  assign tmo_evt = en_r & run & rc_rise & (cnt_r == term_of(period_sel_r)) & ~kick_acc;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!en_r) begin
      cnt_nxt = kwdt_pkg::CNT_RST;
    end else if (kick_acc) begin
      cnt_nxt = kwdt_pkg::CNT_RST;
    end else if (tmo_evt) begin
      cnt_nxt = kwdt_pkg::CNT_RST;
    end else if (run && rc_rise) begin
      cnt_nxt = cnt_r + 32'h00000001;
    end
    rst_req_nxt = tmo_evt;
    rc_en_nxt = en_r;
    grant_nxt = SLEEP_REQ;
    if (en_r && SLEEP_REQ == kwdt_pkg::SLEEP_STATIC) begin
      grant_nxt = kwdt_pkg::SLEEP_SHUTDOWN;
    end
  end

  // The soft reset does not touch this block, so counting goes on through it
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= kwdt_pkg::CNT_RST;
      rc_prev_r <= 1'b0;
      rst_req_r <= 1'b0;
      rc_en_r <= 1'b0;
      grant_r <= kwdt_pkg::SLEEP_RUN;
    end else begin
      cnt_r <= cnt_nxt;
      rc_prev_r <= rc_lvl;
      rst_req_r <= rst_req_nxt;
      rc_en_r <= rc_en_nxt;
      grant_r <= grant_nxt;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign SLEEP_GRANT = grant_r;
  assign RC_OSC_EN = rc_en_r;
  assign WDT_RESET_REQ = rst_req_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  count_step_a: assert property (
    en_r && run && rc_rise && !kick_acc && !tmo_evt |=> cnt_r == $past(cnt_r) + 32'h1)
    else $error("prescaler did not step on an RC edge");

  no_rc_hold_a: assert property (
    en_r && !rc_rise && !kick_acc |=> cnt_r == $past(cnt_r) || !en_r)
    else $error("prescaler moved without an RC edge");

  period_end_a: assert property (
    tmo_evt |-> ({1'b0, cnt_r} + 33'h1) >> (6'(period_sel_r) + 6'h01) == 33'h1)
    else $error("time-out not at two to the select plus one");

  timeout_reset_a: assert property (
    tmo_evt |=> WDT_RESET_REQ ##1 !WDT_RESET_REQ)
    else $error("missing one-cycle reset request on time-out");

  restart_a: assert property (
    tmo_evt |=> cnt_r == 32'h0 && en_r)
    else $error("next period did not restart at once");

  kick_restart_a: assert property (
    kick_acc |=> cnt_r == 32'h0 ##1 !WDT_RESET_REQ)
    else $error("kick did not restart the prescaler");

  stopped_quiet_a: assert property (
    !en_r |=> !WDT_RESET_REQ && cnt_r == 32'h0)
    else $error("stopped watchdog counted or reset");

  rc_on_a: assert property (
    en_r && $past(en_r) |-> RC_OSC_EN)
    else $error("RC clock off while enabled");

  freeze_a: assert property (
    DBG_HALT && !DBG_KEEP_RUN && !kick_acc && en_r |=> $stable(cnt_r) || !en_r)
    else $error("prescaler ran during debug halt");

  key_ignore_a: assert property (
    wr_ctrl && !commit |=> $stable(en_r) && $stable(period_sel_r))
    else $error("control changed without the key sequence");

  key_abort_a: assert property (
    wr_ctrl && wkey == kwdt_pkg::KEY_COMMIT && PWDATA[23:0] != armed_body_r
      |=> lock_r == kwdt_pkg::KWDT_LOCKED && $stable(en_r))
    else $error("mismatched commit did not abort");

  read_zero_a: assert property (
    acc_first && !PWRITE |=> PRDATA[31:24] == 8'h00 &&
      (PRDATA == 32'h0 || $past(PADDR) == kwdt_pkg::ADDR_CTRL))
    else $error("key or kick read back non-zero");

  sleep_map_a: assert property (
    en_r && SLEEP_REQ == kwdt_pkg::SLEEP_STATIC |=> SLEEP_GRANT == kwdt_pkg::SLEEP_SHUTDOWN)
    else $error("static sleep granted while enabled");

  sleep_clk_a: assert property (
    en_r && SLEEP_REQ != kwdt_pkg::SLEEP_RUN |=> ##1 RC_OSC_EN || !$past(en_r))
    else $error("RC clock dropped in sleep");

  kick_guard_a: assert property (
    kick_acc |-> !tmo_evt)
    else $error("time-out despite an accepted kick");

  timeout_c: cover property (tmo_evt ##1 WDT_RESET_REQ);
  kick_c: cover property (kick_acc);
  commit_c: cover property (commit ##1 en_r);
  sleep_c: cover property (en_r && SLEEP_REQ == kwdt_pkg::SLEEP_STATIC);

endmodule

// ===== bench/kwdt_pm_model.sv
// Power manager stand-in: RC oscillator source and reset request counter
`timescale 1ns/1ns
module kwdt_pm_model (
  input wire logic clk,
  input wire logic osc_en,
  input wire logic rst_req,
  output logic rc_clk,
  output int pulses,
  output int gap
);
  logic [2:0] div = 3'h0;
  int cyc = 0;
  int last = 0;
  // ======
  // Oscillator stands still until enabled; four cycles a phase meets the filter
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (osc_en === 1'b1) begin
      div <= div + 3'h1;
    end
    // Count soft reset requests and the spacing between them
    if (rst_req === 1'b1) begin
      pulses <= pulses + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end
  initial begin
    pulses = 0;
    gap = 0;
  end
  assign rc_clk = div[2];
endmodule

// ===== bench/kwdt_tb_top.sv
// Self-checking testbench for the keyed watchdog timer
`timescale 1ns/1ns
module kwdt_tb_top;
  logic CLK_SYS, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RC_CLK;
  logic DBG_HALT, DBG_KEEP_RUN, RC_OSC_EN, WDT_RESET_REQ, rerr;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [2:0] SLEEP_REQ, SLEEP_GRANT;
  int err_total, n_compared, pulses, gap, p0;

  kwdt_top i_dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RC_CLK(RC_CLK), .DBG_HALT(DBG_HALT), .DBG_KEEP_RUN(DBG_KEEP_RUN),
    .SLEEP_REQ(SLEEP_REQ), .SLEEP_GRANT(SLEEP_GRANT), .RC_OSC_EN(RC_OSC_EN),
    .WDT_RESET_REQ(WDT_RESET_REQ));
  kwdt_pm_model i_pm (.clk(CLK_SYS), .osc_en(RC_OSC_EN), .rst_req(WDT_RESET_REQ),
    .rc_clk(RC_CLK), .pulses(pulses), .gap(gap));

  // ======
  // Clock, 4 ns period
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first keeps drivers from clashing
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    // Wait as long as the slave needs; only the bench watchdog ends a hang
    do begin
      @(posedge CLK_SYS);
    end while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h00000000);
    chk(rdat, exp);
    chk(rerr, e);
  endtask

  // Keyed control change: arm then commit with the same body
  task ctl(input logic [23:0] body);
    apb(1'b1, kwdt_pkg::ADDR_CTRL, {kwdt_pkg::KEY_ARM, body});
    apb(1'b1, kwdt_pkg::ADDR_CTRL, {kwdt_pkg::KEY_COMMIT, body});
  endtask

  // Automatic: the watchdog and the tests call it at the same time
  task automatic idle(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  // Bounded wait for the next soft reset request
  task automatic wpulse;
    int n;
    n = 0;
    p0 = pulses;
    while (pulses == p0 && n < 500) begin
      @(posedge CLK_SYS);
      n++;
    end
    if (n >= 500) err_total++;
  endtask

  task complete_run;
    $display("compared=%0d bad=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog of the bench itself; the tests need about 1100 cycles
  initial begin
    idle(8000);
    err_total++;
    complete_run;
  end

  // ======
  // Test sequence
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {DBG_HALT, DBG_KEEP_RUN, SLEEP_REQ, RESETN} = '0;
    err_total = 0;
    n_compared = 0;
    idle(20);
    RESETN <= 1'b1;
    idle(3);
    rdchk(kwdt_pkg::ADDR_CTRL, 32'h00000000, 1'b0);
    apb(1'b1, kwdt_pkg::ADDR_KICK, 32'hFFFFFFFF);
    rdchk(kwdt_pkg::ADDR_KICK, 32'h00000000, 1'b0);
    rdchk(8'h08, 32'h00000000, 1'b1);
    $display("done: reset values");
    // A lone commit and a commit with other bits must both be dropped
    apb(1'b1, kwdt_pkg::ADDR_CTRL, {kwdt_pkg::KEY_COMMIT, 24'h000201});
    rdchk(kwdt_pkg::ADDR_CTRL, 32'h00000000, 1'b0);
    apb(1'b1, kwdt_pkg::ADDR_CTRL, {kwdt_pkg::KEY_ARM, 24'h000201});
    apb(1'b1, kwdt_pkg::ADDR_CTRL, {kwdt_pkg::KEY_COMMIT, 24'h000001});
    rdchk(kwdt_pkg::ADDR_CTRL, 32'h00000000, 1'b0);
    $display("done: key refusal");
    // Period select 2: eight RC edges of eight cycles each
    ctl(24'h000201);
    rdchk(kwdt_pkg::ADDR_CTRL, 32'h00000201, 1'b0);
    chk(RC_OSC_EN, 1'b1);
    wpulse;
    wpulse;
    chk(gap, 64);
    $display("done: time-out");
    // Kicks every 44 cycles keep the reset away
    p0 = pulses;
    repeat (6) begin
      apb(1'b1, kwdt_pkg::ADDR_KICK, 32'h00000000);
      idle(40);
    end
    chk(pulses - p0, 0);
    $display("done: kicks");
    DBG_HALT <= 1'b1;
    idle(5);
    p0 = pulses;
    idle(200);
    chk(pulses - p0, 0);
    DBG_KEEP_RUN <= 1'b1;
    idle(200);
    chk(pulses - p0 > 2, 1);
    {DBG_HALT, DBG_KEEP_RUN} <= 2'b00;
    $display("done: debug");
    SLEEP_REQ <= kwdt_pkg::SLEEP_STATIC;
    idle(3);
    chk(SLEEP_GRANT, kwdt_pkg::SLEEP_SHUTDOWN);
    chk(RC_OSC_EN, 1'b1);
    ctl(24'h000000);
    idle(2);
    chk(SLEEP_GRANT, kwdt_pkg::SLEEP_STATIC);
    chk(RC_OSC_EN, 1'b0);
    p0 = pulses;
    apb(1'b1, kwdt_pkg::ADDR_KICK, 32'h00000000);
    idle(200);
    chk(pulses - p0, 0);
    $display("done: sleep and disable");
    complete_run;
  end
endmodule
